//--- rtl/tcc_pkg.sv
// Package for the capture/compare timer channel
package tcc_pkg;
	localparam logic [7:0] TCC_OFF_CTRL_A = 8'h00;
	localparam logic [7:0] TCC_OFF_CTRL_B = 8'h04;
	localparam logic [7:0] TCC_OFF_EDGE = 8'h08;
	localparam logic [7:0] TCC_OFF_FILT = 8'h0c;
	localparam logic [7:0] TCC_OFF_COUNT = 8'h10;
	localparam logic [7:0] TCC_OFF_CC0 = 8'h14;
	localparam logic [7:0] TCC_OFF_CC1 = 8'h18;
	localparam logic [7:0] TCC_OFF_STAT = 8'h1c;
	// Control A bits
	localparam int TCC_A_CLK_SUP = 0;
	localparam int TCC_A_CNT_EN = 1;
	localparam int TCC_A_OVF = 7;
	// Control B bits
	localparam int TCC_B_MODE0 = 0;
	localparam int TCC_B_MODE1 = 1;
	localparam int TCC_B_MCLR = 3;
	localparam int TCC_B_EXTCLK = 4;
	localparam int TCC_B_ALV = 5;
	localparam int TCC_B_OEN = 6;
	localparam int TCC_B_OSTOP = 7;
	localparam logic [7:0] TCC_CTRL_B_RST = 8'h20;
	localparam logic [7:0] TCC_EDGE_RST = 8'h00;
	localparam logic [1:0] TCC_FILT_RST = 2'h2;
	// Edge codes
	localparam logic [1:0] TCC_EDGE_FALL = 2'h0;
	localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
	localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;
	// Filter widths in filter clocks, filter clock = main clock / 4
	localparam logic [2:0] TCC_FW_1 = 3'h2;
	localparam logic [2:0] TCC_FW_2 = 3'h3;
	localparam logic [2:0] TCC_FW_3 = 3'h5;
	localparam logic [1:0] TCC_FDIV_LAST = 2'h3;
	localparam logic [15:0] TCC_CNT_MAX = 16'hffff;
	localparam logic [15:0] TCC_CNT_ZERO = 16'h0000;
	localparam logic [1:0] TCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] TCC_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} tcc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} tcc_axi_rsp_t;

	typedef struct packed {
		logic trig0;
		logic trig1;
		logic evclk;
	} tcc_pins_t;

	typedef struct packed {
		logic irq_ovf;
		logic irq_ch0;
		logic irq_ch1;
	} tcc_irq_t;
endpackage

//--- rtl/tcc_timer.sv
// Capture/compare timer channel with AXI4-Lite registers
// Function
// - Filter width codes give 0,2,3,5 quarter-clocks
// - Free-running or external event counting
// - Captured value held until next capture
// - Wrap sets overflow flag and interrupt
// - Register zero FFFF match-clear suppresses overflow
// - Clearing by count-enable drop is no overflow
// - Overflow stop halts until enable written
// - Enable rewrite while counting has no effect
// - Mode bit picks capture or compare
// - Capture latches count on valid trigger edge
// - Every valid trigger edge in capture mode raises channel interrupt
// - Edge select: rising, falling or both
// - Compare match drives output and interrupt together
// - Zero compare matches only wrapped zero
// - Match clear resets counter on register zero
// - Register zero sets, register one resets output
// - Enable and active level set pin level
// - One pulse output pin per channel
// - Interval use: clear, interrupt, keep counting
// - Clock-supply bit low holds counter reset
// - Read colliding with capture skips store
// - Independent edge select per input
`timescale 1ns/1ns
module tcc_timer
	import tcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire tcc_pkg::tcc_axi_req_t axi_req,
	output tcc_pkg::tcc_axi_rsp_t axi_rsp,
	input wire tcc_pkg::tcc_pins_t pins,
	input wire logic count_tick,
	output logic pulse_output_pin,
	output tcc_pkg::tcc_irq_t irq
);
	import tcc_pkg::*;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [1:0] fdiv;
		logic [2:0][2:0] fcnt;
		logic [2:0] filt;
		logic [15:0] up_counter;
		logic [15:0] capcmp_reg_zero;
		logic [15:0] capcmp_reg_one;
		logic count_enable_bit;
		logic clock_supply_enable;
		logic overflow_flag;
		logic [7:0] ctrl_b;
		logic [7:0] edge_select_reg;
		logic [1:0] input_noise_filter_width;
		logic wrapped;
		logic fresh;
		logic stopped;
		logic out_ff;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic pin_lvl;
		tcc_irq_t irq;
	} tcc_state_t;

	tcc_state_t st_reg;
	tcc_state_t st_next;

	logic [2:0] width_clks;
	logic [2:0] edge_hit;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [1:0] esel [3];
	logic do_write;
	logic do_read;
	logic filt_tick;
	logic tick;
	logic run;
	logic mode0;
	logic mode1;
	logic match0;
	logic match1;
	logic mclr;
	logic eq0;
	logic eq1;
	logic [2:0] filt_nx;
	logic [2:0][2:0] fcnt_nx;
	logic [15:0] cnt_inc;
	logic [31:0] rd_val;
	logic rd_hit;

	always_comb begin
		unique case (st_reg.input_noise_filter_width)
			2'h0: width_clks = 3'h0;
			2'h1: width_clks = TCC_FW_1;
			2'h2: width_clks = TCC_FW_2;
			2'h3: width_clks = TCC_FW_3;
		endcase
	end

	assign filt_tick = (st_reg.fdiv == TCC_FDIV_LAST);
	// Edge selects: trigger zero bits 1:0, trigger one bits 3:2, event clock bits 7:6
	assign esel[0] = st_reg.edge_select_reg[1:0];
	assign esel[1] = st_reg.edge_select_reg[3:2];
	assign esel[2] = st_reg.edge_select_reg[7:6];

	// Kept apart so edge detection feeds the counter without a loop
	always_comb begin
		filt_nx = st_reg.filt;
		fcnt_nx = st_reg.fcnt;
		for (int i = 0; i < 3; i++) begin
			if (width_clks == 3'h0) begin
				filt_nx[i] = st_reg.s2[i];
				fcnt_nx[i] = 3'h0;
			end else if (st_reg.s2[i] == st_reg.filt[i]) begin
				fcnt_nx[i] = 3'h0;
			end else if (filt_tick) begin
				if (st_reg.fcnt[i] + 3'h1 >= width_clks) begin
					filt_nx[i] = st_reg.s2[i];
					fcnt_nx[i] = 3'h0;
				end else begin
					fcnt_nx[i] = st_reg.fcnt[i] + 3'h1;
				end
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_edge
			assign rise[gi] = filt_nx[gi] & ~st_reg.filt[gi];
			assign fall[gi] = ~filt_nx[gi] & st_reg.filt[gi];
			// Code 2 is prohibited and simply detects nothing
			assign edge_hit[gi] = ((esel[gi] == TCC_EDGE_RISE) & rise[gi]) |
				((esel[gi] == TCC_EDGE_FALL) & fall[gi]) |
				((esel[gi] == TCC_EDGE_BOTH) & (rise[gi] | fall[gi]));
		end
	endgenerate

	assign mode0 = st_reg.ctrl_b[TCC_B_MODE0];
	assign mode1 = st_reg.ctrl_b[TCC_B_MODE1];
	assign run = st_reg.clock_supply_enable & st_reg.count_enable_bit & ~st_reg.stopped;
	assign tick = run & (st_reg.ctrl_b[TCC_B_EXTCLK] ? edge_hit[2] : count_tick);
	// Zero compares only count on the zero reached by wrapping
	assign eq0 = mode0 & (st_reg.up_counter == st_reg.capcmp_reg_zero) &
		((st_reg.up_counter != TCC_CNT_ZERO) | st_reg.wrapped);
	assign eq1 = mode1 & (st_reg.up_counter == st_reg.capcmp_reg_one) &
		((st_reg.up_counter != TCC_CNT_ZERO) | st_reg.wrapped);
	// A slow count clock holds a value many cycles; only its first cycle matches
	assign match0 = eq0 & st_reg.fresh;
	assign match1 = eq1 & st_reg.fresh;
	assign mclr = eq0 & st_reg.ctrl_b[TCC_B_MCLR];
	assign cnt_inc = st_reg.up_counter + 16'h0001;

	assign do_write = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
	assign do_read = axi_req.arvalid & ~st_reg.rvalid;

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (axi_req.araddr)
			TCC_OFF_CTRL_A: rd_val = {24'h0, st_reg.overflow_flag, 5'h0,
				st_reg.count_enable_bit, st_reg.clock_supply_enable};
			TCC_OFF_CTRL_B: rd_val = {24'h0, st_reg.ctrl_b};
			TCC_OFF_EDGE: rd_val = {24'h0, st_reg.edge_select_reg};
			TCC_OFF_FILT: rd_val = {30'h0, st_reg.input_noise_filter_width};
			TCC_OFF_COUNT: rd_val = {16'h0, st_reg.up_counter};
			TCC_OFF_CC0: rd_val = {16'h0, st_reg.capcmp_reg_zero};
			TCC_OFF_CC1: rd_val = {16'h0, st_reg.capcmp_reg_one};
			TCC_OFF_STAT: rd_val = {29'h0, st_reg.filt};
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.irq = '0;
		// Synchronise pins before any filtering
		st_next.s1 = {pins.evclk, pins.trig1, pins.trig0};
		st_next.s2 = st_reg.s1;
		st_next.fdiv = st_reg.fdiv + 2'h1;
		st_next.filt = filt_nx;
		st_next.fcnt = fcnt_nx;

		// Counter
		st_next.fresh = tick;
		if (tick) begin
			if (mclr) begin
				st_next.up_counter = TCC_CNT_ZERO;
				st_next.wrapped = 1'b0;
			end else if (st_reg.up_counter == TCC_CNT_MAX) begin
				// An FFFF match-clear was handled above, so this is a true wrap
				st_next.up_counter = TCC_CNT_ZERO;
				st_next.wrapped = 1'b1;
				st_next.overflow_flag = 1'b1;
				st_next.irq.irq_ovf = 1'b1;
				if (st_reg.ctrl_b[TCC_B_OSTOP]) begin
					st_next.stopped = 1'b1;
				end
			end else begin
				st_next.up_counter = cnt_inc;
				st_next.wrapped = 1'b0;
			end
		end

		// Compare match: output and interrupt in the same cycle
		if (match0) begin
			st_next.irq.irq_ch0 = 1'b1;
		end
		if (match1) begin
			st_next.irq.irq_ch1 = 1'b1;
		end
		// Reset wins when both match, so equal values keep the output inactive
		if (match1) begin
			st_next.out_ff = 1'b0;
		end else if (match0) begin
			st_next.out_ff = 1'b1;
		end

		// Capture: a read of the same register this cycle blocks the store
		if (!mode0 && edge_hit[0]) begin
			st_next.irq.irq_ch0 = 1'b1;
			if (!(do_read && axi_req.araddr == TCC_OFF_CC0)) begin
				st_next.capcmp_reg_zero = st_reg.up_counter;
			end
		end
		if (!mode1 && edge_hit[1]) begin
			st_next.irq.irq_ch1 = 1'b1;
			if (!(do_read && axi_req.araddr == TCC_OFF_CC1)) begin
				st_next.capcmp_reg_one = st_reg.up_counter;
			end
		end

		// Pin level from enable and active level
		if (st_reg.ctrl_b[TCC_B_OEN]) begin
			st_next.pin_lvl = st_next.out_ff ~^ st_reg.ctrl_b[TCC_B_ALV];
		end else begin
			st_next.pin_lvl = ~st_reg.ctrl_b[TCC_B_ALV];
		end

		// AXI write channel
		if (axi_req.awvalid && !st_reg.aw_got) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !st_reg.w_got) begin
			st_next.w_got = 1'b1;
			st_next.w_data = axi_req.wdata;
			st_next.w_strb = axi_req.wstrb;
		end
		if (do_write) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = TCC_RESP_OKAY;
			if (st_reg.w_strb[0]) begin
				unique case (st_reg.aw_addr)
					TCC_OFF_CTRL_A: begin
						st_next.clock_supply_enable = st_reg.w_data[TCC_A_CLK_SUP];
						if (st_reg.w_data[TCC_A_CNT_EN]) begin
							// Restarts only a stopped counter; running count untouched
							st_next.stopped = 1'b0;
						end
						st_next.count_enable_bit = st_reg.w_data[TCC_A_CNT_EN];
						if (!st_reg.w_data[TCC_A_OVF]) begin
							st_next.overflow_flag = st_next.irq.irq_ovf;
						end
					end
					TCC_OFF_CTRL_B: st_next.ctrl_b = st_reg.w_data[7:0];
					TCC_OFF_EDGE: st_next.edge_select_reg = st_reg.w_data[7:0];
					TCC_OFF_FILT: st_next.input_noise_filter_width = st_reg.w_data[1:0];
					TCC_OFF_CC0: begin
						if (mode0) begin
							st_next.capcmp_reg_zero[7:0] = st_reg.w_data[7:0];
						end
					end
					TCC_OFF_CC1: begin
						if (mode1) begin
							st_next.capcmp_reg_one[7:0] = st_reg.w_data[7:0];
						end
					end
					TCC_OFF_COUNT, TCC_OFF_STAT: begin
					end
					default: st_next.bresp = TCC_RESP_SLVERR;
				endcase
			end
			if (st_reg.w_strb[1]) begin
				if (st_reg.aw_addr == TCC_OFF_CC0 && mode0) begin
					st_next.capcmp_reg_zero[15:8] = st_reg.w_data[15:8];
				end
				if (st_reg.aw_addr == TCC_OFF_CC1 && mode1) begin
					st_next.capcmp_reg_one[15:8] = st_reg.w_data[15:8];
				end
			end
		end
		if (st_reg.bvalid && axi_req.bready) begin
			st_next.bvalid = 1'b0;
		end

		// AXI read channel
		if (do_read) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_val;
			st_next.rresp = rd_hit ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
		end
		if (st_reg.rvalid && axi_req.rready) begin
			st_next.rvalid = 1'b0;
		end

		// Count enable low or clock supply low forces a clear, never an overflow
		if (!st_next.count_enable_bit || !st_next.clock_supply_enable) begin
			st_next.up_counter = TCC_CNT_ZERO;
			st_next.wrapped = 1'b0;
			st_next.stopped = 1'b0;
		end
		if (!st_next.clock_supply_enable) begin
			st_next.overflow_flag = 1'b0;
			st_next.out_ff = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.ctrl_b <= TCC_CTRL_B_RST;
			st_reg.edge_select_reg <= TCC_EDGE_RST;
			st_reg.input_noise_filter_width <= TCC_FILT_RST;
			st_reg.pin_lvl <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Single channel instance; a six-channel timer places six of these, one pin each
	assign pulse_output_pin = st_reg.pin_lvl;
	assign irq = st_reg.irq;

	always_comb begin
		axi_rsp = '0;
		axi_rsp.awready = ~st_reg.aw_got;
		axi_rsp.wready = ~st_reg.w_got;
		axi_rsp.bvalid = st_reg.bvalid;
		axi_rsp.bresp = st_reg.bresp;
		axi_rsp.arready = ~st_reg.rvalid;
		axi_rsp.rvalid = st_reg.rvalid;
		axi_rsp.rdata = st_reg.rdata;
		axi_rsp.rresp = st_reg.rresp;
	end
endmodule

//--- bench/tcc_timer_chk.sv
// Port checker for the timer channel
`timescale 1ns/1ns
module tcc_timer_chk
	import tcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire tcc_pkg::tcc_axi_req_t axi_req,
	input wire tcc_pkg::tcc_axi_rsp_t axi_rsp,
	input wire logic pulse_output_pin,
	input wire tcc_pkg::tcc_irq_t irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_B_AFTER: assert property ($rose(axi_rsp.bvalid) |->
		!$past(axi_rsp.awready) && !$past(axi_rsp.wready)) else $error("early write answer");
	AST_R_AFTER: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
	AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=>
		axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
	AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=>
		axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read answer dropped");
	AST_AR_BLOCK: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read taken while answer pending");
	AST_R_ERR_ZERO: assert property (axi_rsp.rvalid && axi_rsp.rresp == TCC_RESP_SLVERR |->
		axi_rsp.rdata == 32'h0) else $error("error read not zero");
	AST_OVF_PULSE: assert property (irq.irq_ovf |=> !irq.irq_ovf)
		else $error("overflow pulse too long");
	AST_PIN_CAUSE: assert property ($changed(pulse_output_pin) |-> irq.irq_ch0 ||
		irq.irq_ch1 || $past(axi_rsp.bvalid) || $past(axi_rsp.bvalid, 2))
		else $error("pin moved without cause");
endmodule
bind tcc_timer tcc_timer_chk tcc_timer_chk_inst(.aclk(aclk), .aresetn(aresetn),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .pulse_output_pin(pulse_output_pin), .irq(irq));

//--- bench/tcc_pin_model.sv
// Drive model for the trigger and event clock pins
`timescale 1ns/1ns
module tcc_pin_model
	import tcc_pkg::*;
(
	input wire logic aclk,
	output tcc_pkg::tcc_pins_t pins
);
	initial pins = '0;
	// Called just after an edge, so the level moves off the sampling edge
	task automatic setp(input int i, input logic v);
		pins[i] <= v;
	endtask
endmodule

//--- bench/timer_capture_compare_unit_tb_top.sv
// Self-checking bench for the capture/compare timer channel
`timescale 1ns/1ns
module timer_capture_compare_unit_tb_top;
	import tcc_pkg::*;
	logic aclk;
	logic aresetn;
	logic count_tick;
	logic pulse_output_pin;
	logic pwm;
	logic alv;
	tcc_axi_req_t req;
	tcc_axi_rsp_t rsp;
	tcc_pins_t pins;
	tcc_irq_t irq;
	int fail_count;
	int tests_run;
	int k;
	int ic[3];
	int ex[3];
	int fw[4];
	logic [33:0] exp_q[$];
	tcc_timer tcc_timer_inst(.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.pins(pins), .count_tick(count_tick), .pulse_output_pin(pulse_output_pin), .irq(irq));
	tcc_pin_model tcc_pin_model_inst(.aclk(aclk), .pins(pins));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic end_sim;
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bail;
		fail_count++;
		$display("Error %0t: wait ran out", $time);
		end_sim();
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		int n;
		logic done;
		n = 0;
		req.awaddr <= a;
		req.wdata <= {16'h0, d};
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'($urandom_range(0, 1));
		do begin
			@(posedge aclk);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			done = rsp.bvalid && req.bready;
			if (!done) req.bready <= 1'b1;
		end while (!done && n < 50);
		if (!done) bail();
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		int n;
		logic done;
		n = 0;
		exp_q.push_back({r, e});
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'($urandom_range(0, 1));
		do begin
			@(posedge aclk);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			done = rsp.rvalid && req.rready;
			if (!done) req.rready <= 1'b1;
		end while (!done && n < 50);
		if (!done) bail();
	endtask
	task automatic tick(input int t);
		count_tick <= 1'b1;
		repeat (t) @(posedge aclk);
		count_tick <= 1'b0;
	endtask
	task automatic pin(input int i, input logic v, input int w);
		tcc_pin_model_inst.setp(i, v);
		repeat (w) @(posedge aclk);
	endtask
	task automatic cirq;
		for (int i = 0; i < 3; i++)
			chk(34'(ic[i]), 34'(ex[i]));
	endtask
	// Read data and interrupt pulses are judged apart from the driver
	always @(posedge aclk) begin
		if (aresetn && rsp.rvalid && req.rready)
			chk({rsp.rresp, rsp.rdata}, exp_q.pop_front());
		for (int i = 0; i < 3; i++)
			if (aresetn && irq[i] === 1'b1)
				ic[i]++;
		if (pwm && irq.irq_ch0 === 1'b1)
			chk(34'(pulse_output_pin), 34'(alv));
		if (pwm && irq.irq_ch1 === 1'b1)
			chk(34'(pulse_output_pin), 34'(!alv));
	end
	initial begin
		aresetn = 1'b0;
		req = '0;
		req.wstrb = 4'hf;
		count_tick = 1'b0;
		pwm = 1'b0;
		alv = 1'b0;
		fail_count = 0;
		tests_run = 0;
		fw = '{0, TCC_FW_1, TCC_FW_2, TCC_FW_3};
		k = $urandom(60349);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(TCC_OFF_CTRL_A, 32'h0);
		rd(TCC_OFF_CTRL_B, 32'(TCC_CTRL_B_RST));
		rd(TCC_OFF_EDGE, 32'(TCC_EDGE_RST));
		rd(TCC_OFF_FILT, 32'(TCC_FILT_RST));
		rd(8'h20, 32'h0, TCC_RESP_SLVERR);
		wr(TCC_OFF_FILT, 16'h0);
		wr(TCC_OFF_EDGE, 16'h7);
		wr(TCC_OFF_CTRL_A, 16'h3);
		k = $urandom_range(1, 300);
		tick(k);
		pin(2, 1'b1, 8);
		rd(TCC_OFF_CC0, 32'(k));
		tick(5);
		pin(2, 1'b0, 8);
		tick(3);
		pin(1, 1'b0, 8);
		pin(1, 1'b1, 8);
		pin(1, 1'b0, 8);
		rd(TCC_OFF_CC0, 32'(k + 5));
		rd(TCC_OFF_CC1, 32'(k + 8));
		ex[1] = 2;
		ex[0] = 1;
		cirq();
		for (int c = 0; c < 4; c++) begin
			wr(TCC_OFF_FILT, 16'(c));
			if (fw[c] > 0)
				pin(2, 1'b1, 4 * fw[c] - 4);
			pin(2, 1'b0, 40);
			pin(2, 1'b1, 4 * fw[c] + 4);
			pin(2, 1'b0, 40);
			ex[1] += 2;
			cirq();
		end
		wr(TCC_OFF_CTRL_A, 16'h1);
		rd(TCC_OFF_COUNT, 32'h0);
		wr(TCC_OFF_CTRL_B, 16'h31);
		wr(TCC_OFF_EDGE, 16'h40);
		wr(TCC_OFF_CTRL_A, 16'h3);
		for (int i = 0; i < 3; i++) begin
			pin(0, 1'b1, 24);
			pin(0, 1'b0, 24);
		end
		rd(TCC_OFF_COUNT, 32'h3);
		for (int a = 0; a < 2; a++) begin
			alv <= a[0];
			wr(TCC_OFF_CTRL_A, 16'h0);
			wr(TCC_OFF_CTRL_B, 16'h4b | {10'h0, alv, 5'h0});
			wr(TCC_OFF_CC0, 16'd10);
			wr(TCC_OFF_CC1, 16'd5);
			@(posedge aclk);
			chk(34'(pulse_output_pin), 34'(!alv));
			pwm <= 1'b1;
			wr(TCC_OFF_CTRL_A, 16'h3);
			tick(20);
			repeat (2) @(posedge aclk);
			pwm <= 1'b0;
			ex[1] += 1;
			ex[0] += 2;
			cirq();
			rd(TCC_OFF_COUNT, 32'h9);
			wr(TCC_OFF_CTRL_A, 16'h1);
			wr(TCC_OFF_CTRL_B, 16'h0b | {10'h0, alv, 5'h0});
			@(posedge aclk);
			chk(34'(pulse_output_pin), 34'(!alv));
		end
		wr(TCC_OFF_CTRL_A, 16'h1);
		wr(TCC_OFF_CTRL_B, 16'ha2);
		wr(TCC_OFF_CC1, 16'h0);
		wr(TCC_OFF_CTRL_A, 16'h3);
		tick(65540);
		rd(TCC_OFF_COUNT, 32'h0);
		rd(TCC_OFF_CTRL_A, 32'h83);
		ex[2] = 1;
		ex[0] += 1;
		cirq();
		wr(TCC_OFF_CTRL_A, 16'h3);
		tick(4);
		wr(TCC_OFF_CTRL_A, 16'h3);
		tick(2);
		rd(TCC_OFF_COUNT, 32'h6);
		end_sim();
	end
endmodule
